//--- src/ccs_ctrl_port.sv
// Control port: 3-wire serial and two-wire bus slave onto a register file.
// Assumes the 3-wire clock only toggles while chip select is low and
// runs well below the core clock; the two-wire pins are oversampled.
`timescale 1ns/1ps
`default_nettype none
module ccs_ctrl_port (
  // Core clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Device straps and reset pin
  input  wire logic        chip_reset_low,
  input  wire logic        bus_address_select_pin,
  input  wire logic        i2c_mode_sel,
  // 3-wire link
  input  wire logic        control_serial_clock,
  input  wire logic        serial_select_low,
  input  wire logic        control_data_line_in,
  output logic             control_data_line_out,
  output logic             control_data_line_oe,
  // Two-wire link (open drain)
  input  wire logic        i2c_clock_in,
  input  wire logic        i2c_data_in,
  output logic             i2c_data_out,
  output logic             i2c_data_oe,
  // Register contents to the codec core
  output logic [8*ccs_pkg::REG_COUNT-1:0] config_image
);

  // Link-domain state
  logic [4:0]             tw_cnt_r;
  ccs_pkg::ccs_tw_frame_s tw_sr_r;
  logic                   tw_dir_r;
  logic                   tw_full_r;
  logic                   tw_req_r;
  logic                   tw_oe_r;
  logic                   tw_dout_r;
  logic [4:0]             tw_idx;

  // Core-domain state
  logic [6:0]   sync_q;
  logic         cs_s, pdn_s, cad_s, mode_s, scl_s, sda_s, req_s;
  logic         cs_q, scl_q, sda_q, req_q;
  logic         int_rst, cs_rise, scl_rise, scl_fall;
  logic         start_c, stop_c;
  logic [7:0]   regs_r [0:ccs_pkg::REG_COUNT-1];
  logic [7:0]   tw_rd_r;
  ccs_pkg::ccs_i2c_st_e st_r;
  logic [3:0]   bc_r;
  logic [7:0]   sh_r;
  logic [7:0]   tx_r;
  logic [6:0]   cnt_r;
  logic [6:0]   cnt_inc;
  logic         rw_r, mack_r, oe_r;
  logic         byte_in, addr_match, tx_load;
  logic [7:0]   cur_byte;
  logic [3:0]   tx_pos;
  logic         tw_we, i2c_we, wr_en;
  logic [6:0]   wr_addr;
  logic [7:0]   wr_data;

  // Table lookup with the unreadable holes forced to zero
  function automatic logic [7:0] rd_byte(input logic [6:0] a,
                                         input logic       i2c);
    rd_byte = ccs_pkg::reg_readable(a, i2c) ? regs_r[a] : 8'h00;
  endfunction

  // ---- 3-wire link, on the host's serial clock ----

  // Bit counter; chip select high is this domain's reset
  always_ff @(posedge control_serial_clock or
              posedge serial_select_low) begin
    if (serial_select_low) begin
      tw_cnt_r <= 5'h00;
    end else if (tw_cnt_r != ccs_pkg::TW_FRAME_BITS) begin
      tw_cnt_r <= tw_cnt_r + 5'h01;
    end
  end

  // Shift in on rise; frozen once a read header is in
  always_ff @(posedge control_serial_clock) begin
    if (tw_cnt_r < ccs_pkg::TW_HDR_BITS ||
        (tw_cnt_r < ccs_pkg::TW_FRAME_BITS &&
         tw_dir_r != ccs_pkg::TW_DIR_READ)) begin
      tw_sr_r <= {tw_sr_r[14:0], control_data_line_in};
    end
  end

  // Direction latched with the eighth bit; frame-complete flag
  always_ff @(posedge control_serial_clock) begin
    if (tw_cnt_r == ccs_pkg::TW_HDR_LAST) begin
      tw_dir_r <= tw_sr_r[6];
    end
    if (tw_cnt_r == 5'h00) begin
      tw_full_r <= 1'b0;
    end else if (tw_cnt_r == ccs_pkg::TW_LAST_BIT) begin
      tw_full_r <= 1'b1;
    end
  end

  // Read request level, raised after the header, dropped by chip select
  always_ff @(posedge control_serial_clock or
              posedge serial_select_low) begin
    if (serial_select_low) begin
      tw_req_r <= 1'b0;
    end else if (tw_cnt_r == ccs_pkg::TW_HDR_LAST &&
                 tw_sr_r[6] == ccs_pkg::TW_DIR_READ) begin
      tw_req_r <= 1'b1;
    end
  end

  // Drive from the eighth fall until chip select rises
  always_ff @(negedge control_serial_clock or
              posedge serial_select_low) begin
    if (serial_select_low) begin
      tw_oe_r <= 1'b0;
    end else if (tw_cnt_r == ccs_pkg::TW_HDR_BITS &&
                 tw_dir_r == ccs_pkg::TW_DIR_READ) begin
      tw_oe_r <= 1'b1;
    end
  end

  // Read byte is stable by now: loaded a few core cycles after the rise
  assign tw_idx = ccs_pkg::TW_LAST_BIT - tw_cnt_r;
  always_ff @(negedge control_serial_clock or
              posedge serial_select_low) begin
    if (serial_select_low) begin
      tw_dout_r <= 1'b0;
    end else if (tw_cnt_r >= ccs_pkg::TW_HDR_BITS &&
                 tw_cnt_r < ccs_pkg::TW_FRAME_BITS) begin
      tw_dout_r <= tw_rd_r[tw_idx[2:0]];
    end
  end

  assign control_data_line_out = tw_dout_r;
  assign control_data_line_oe  = tw_oe_r;

  // ---- Core domain ----

  // Every pin but the 3-wire clock and data line, and the link request, pass two flops
  ccs_sync #(.W(7), .INIT(ccs_pkg::SYNC_INIT)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({serial_select_low, chip_reset_low,
             bus_address_select_pin, i2c_mode_sel,
             i2c_clock_in, i2c_data_in, tw_req_r}),
    .q     (sync_q)
  );
  assign {cs_s, pdn_s, cad_s, mode_s, scl_s, sda_s, req_s} = sync_q;

  // Power-down pin acts as a register reset
  assign int_rst = !rst_n || !pdn_s;

  // Previous samples for edge detection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_q  <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      req_q <= 1'b0;
    end else begin
      cs_q  <= cs_s;
      scl_q <= scl_s;
      sda_q <= sda_s;
      req_q <= req_s;
    end
  end

  // Edges and bus conditions
  assign cs_rise  = cs_s && !cs_q;
  assign scl_rise = scl_s && !scl_q;
  assign scl_fall = !scl_s && scl_q;
  assign start_c  = scl_s && scl_q && sda_q && !sda_s;
  assign stop_c   = scl_s && scl_q && !sda_q && sda_s;

  // Fetch 3-wire read data once the header is held
  always_ff @(posedge clk) begin
    if (int_rst) begin
      tw_rd_r <= 8'h00;
    end else if (req_s && !req_q) begin
      tw_rd_r <= rd_byte(tw_sr_r[6:0], 1'b0);
    end
  end

  // Link shift register is idle once chip select is high.
  // Direction comes from the latched copy: a read frame freezes the shift
  // register after its header, so its top field still holds the old frame.
  assign tw_we = cs_rise && !mode_s && tw_full_r &&
                 tw_dir_r != ccs_pkg::TW_DIR_READ &&
                 tw_sr_r.addr <= ccs_pkg::REG_LAST;

  // ---- Two-wire slave ----

  assign byte_in    = (bc_r == ccs_pkg::BYTE_BITS);
  assign addr_match = (sh_r[7:1] ==
                       {ccs_pkg::DEV_ADDR_HI, cad_s});
  assign cur_byte   = rd_byte(cnt_r, 1'b1);
  assign cnt_inc    = (cnt_r >= ccs_pkg::REG_LAST) ? 7'h00
                                                   : cnt_r + 7'h01;
  assign tx_load    = mode_s && scl_fall &&
                      ((st_r == ccs_pkg::ST_ACK_A && rw_r) ||
                       (st_r == ccs_pkg::ST_RACK && mack_r));
  assign i2c_we     = mode_s && scl_fall && byte_in &&
                      st_r == ccs_pkg::ST_WDATA &&
                      cnt_r <= ccs_pkg::REG_LAST;
  assign tx_pos     = {1'b0, ccs_pkg::BIT_TOP} - bc_r;

  // Bit sampling on clock rise
  always_ff @(posedge clk) begin
    if (int_rst || start_c) begin
      bc_r   <= 4'h0;
      sh_r   <= 8'h00;
      mack_r <= 1'b0;
    end else if (scl_rise) begin
      unique case (st_r)
        ccs_pkg::ST_ADDR, ccs_pkg::ST_REG, ccs_pkg::ST_WDATA: begin
          sh_r <= {sh_r[6:0], sda_s};
          bc_r <= bc_r + 4'h1;
        end
        ccs_pkg::ST_RDATA: bc_r <= bc_r + 4'h1;
        ccs_pkg::ST_RACK:  mack_r <= !sda_s;
        default: ;
      endcase
    end else if (scl_fall && (st_r == ccs_pkg::ST_ACK_A ||
                              st_r == ccs_pkg::ST_ACK_R ||
                              st_r == ccs_pkg::ST_ACK_W ||
                              st_r == ccs_pkg::ST_RACK)) begin
      bc_r <= 4'h0;
    end
  end

  // Slave sequence; the pin only moves after a clock fall
  always_ff @(posedge clk) begin
    if (int_rst || !mode_s) begin
      st_r <= ccs_pkg::ST_IDLE;
      oe_r <= 1'b0;
      rw_r <= 1'b0;
    end else if (stop_c) begin
      st_r <= ccs_pkg::ST_IDLE;
      oe_r <= 1'b0;
    end else if (start_c) begin
      st_r <= ccs_pkg::ST_ADDR;
      oe_r <= 1'b0;
    end else if (scl_fall) begin
      unique case (st_r)
        ccs_pkg::ST_IDLE: ;
        ccs_pkg::ST_ADDR: begin
          if (byte_in && addr_match) begin
            st_r <= ccs_pkg::ST_ACK_A;
            oe_r <= 1'b1;
            rw_r <= sh_r[0];
          end else if (byte_in) begin
            st_r <= ccs_pkg::ST_IDLE;
          end
        end
        ccs_pkg::ST_REG: begin
          if (byte_in) begin
            st_r <= ccs_pkg::ST_ACK_R;
            oe_r <= 1'b1;
          end
        end
        ccs_pkg::ST_WDATA: begin
          if (byte_in) begin
            st_r <= ccs_pkg::ST_ACK_W;
            oe_r <= 1'b1;
          end
        end
        ccs_pkg::ST_ACK_A: begin
          if (rw_r) begin
            st_r <= ccs_pkg::ST_RDATA;
            oe_r <= !cur_byte[7];
          end else begin
            st_r <= ccs_pkg::ST_REG;
            oe_r <= 1'b0;
          end
        end
        ccs_pkg::ST_ACK_R, ccs_pkg::ST_ACK_W: begin
          st_r <= ccs_pkg::ST_WDATA;
          oe_r <= 1'b0;
        end
        ccs_pkg::ST_RDATA: begin
          if (byte_in) begin
            st_r <= ccs_pkg::ST_RACK;
            oe_r <= 1'b0;
          end else begin
            oe_r <= !tx_r[tx_pos[2:0]];
          end
        end
        ccs_pkg::ST_RACK: begin
          if (mack_r) begin
            st_r <= ccs_pkg::ST_RDATA;
            oe_r <= !cur_byte[7];
          end else begin
            st_r <= ccs_pkg::ST_IDLE;
            oe_r <= 1'b0;
          end
        end
      endcase
    end
  end

  // Transmit byte
  always_ff @(posedge clk) begin
    if (int_rst) begin
      tx_r <= 8'h00;
    end else if (tx_load) begin
      tx_r <= cur_byte;
    end
  end

  // Address counter: set by register byte, bumped per data byte
  always_ff @(posedge clk) begin
    if (int_rst) begin
      cnt_r <= 7'h00;
    end else if (mode_s && scl_fall && byte_in &&
                 st_r == ccs_pkg::ST_REG) begin
      cnt_r <= sh_r[6:0];
    end else if (i2c_we || tx_load) begin
      cnt_r <= cnt_inc;
    end
  end

  // Open drain: only ever pulls low
  assign i2c_data_out = 1'b0;
  assign i2c_data_oe  = oe_r;

  // ---- Register file ----

  // Modes are exclusive, so the two writers never collide
  assign wr_en   = tw_we || i2c_we;
  assign wr_addr = mode_s ? cnt_r : tw_sr_r.addr;
  assign wr_data = mode_s ? sh_r  : tw_sr_r.data;

  always_ff @(posedge clk) begin
    if (int_rst) begin
      for (int i = 0; i < ccs_pkg::REG_COUNT; i++) begin
        regs_r[i] <= ccs_pkg::REG_INIT;
      end
    end else if (wr_en) begin
      regs_r[wr_addr] <= wr_data;
    end
  end

  // Flatten for the codec core
  always_comb begin
    for (int i = 0; i < ccs_pkg::REG_COUNT; i++) begin
      config_image[i*8 +: 8] = regs_r[i];
    end
  end

  // ---- Checks ----

  chk_tw_commit: assert property (@(posedge clk) disable iff (int_rst)
    tw_we |=> regs_r[$past(tw_sr_r.addr)] == $past(tw_sr_r.data))
    else $error("3-wire write not committed");

  chk_tw_short_drop: assert property (@(posedge clk)
    disable iff (int_rst)
    (cs_rise && !tw_full_r && !mode_s) |=> $stable(config_image))
    else $error("short 3-wire frame changed a register");

  chk_tw_oe_late: assert property (@(posedge control_serial_clock)
    disable iff (serial_select_low)
    tw_cnt_r < ccs_pkg::TW_HDR_BITS |-> !tw_oe_r)
    else $error("3-wire line driven before read data");

  chk_tw_oe_read: assert property (@(posedge control_serial_clock)
    disable iff (serial_select_low)
    (tw_cnt_r == ccs_pkg::TW_HDR_BITS &&
     tw_dir_r == ccs_pkg::TW_DIR_READ) |-> tw_oe_r)
    else $error("3-wire read not driven after eighth fall");

  chk_pdn_regs: assert property (@(posedge clk) disable iff (!rst_n)
    !pdn_s |=> config_image == {ccs_pkg::REG_COUNT{ccs_pkg::REG_INIT}})
    else $error("registers not cleared by power-down");

  chk_i2c_addr_ack: assert property (@(posedge clk)
    disable iff (int_rst || !mode_s)
    (st_r == ccs_pkg::ST_ADDR && scl_fall && byte_in && !stop_c &&
     !start_c) |=> (oe_r == addr_match ## 0
                    st_r == (addr_match ? ccs_pkg::ST_ACK_A
                                        : ccs_pkg::ST_IDLE)) ##0 1)
    else $error("address acknowledge wrong");

  chk_i2c_wr_ack: assert property (@(posedge clk)
    disable iff (int_rst || !mode_s)
    (st_r == ccs_pkg::ST_WDATA && scl_fall && byte_in) |=>
    oe_r ##1 (oe_r throughout (!scl_fall)[*1]))
    else $error("write byte not acknowledged");

  chk_i2c_wrap: assert property (@(posedge clk)
    disable iff (int_rst)
    ((i2c_we || tx_load) && cnt_r == ccs_pkg::REG_LAST) |=>
    cnt_r == 7'h00)
    else $error("address counter did not wrap after last");

  chk_i2c_rd_inc: assert property (@(posedge clk)
    disable iff (int_rst)
    (tx_load && cnt_r < ccs_pkg::REG_LAST) |=>
    (cnt_r == $past(cnt_r) + 7'h01 && tx_r == $past(cur_byte)))
    else $error("current read byte or increment wrong");

  chk_i2c_nack_end: assert property (@(posedge clk)
    disable iff (int_rst || !mode_s)
    (st_r == ccs_pkg::ST_RACK && scl_fall && !mack_r) |=>
    (st_r == ccs_pkg::ST_IDLE && !oe_r) [*2])
    else $error("slave kept sending after no-acknowledge");

  chk_i2c_pin_move: assert property (@(posedge clk)
    disable iff (int_rst || !mode_s)
    $rose(oe_r) |-> $past(scl_fall))
    else $error("data pulled low outside clock low");

  chk_i2c_hole: assert property (@(posedge clk)
    disable iff (int_rst)
    (tx_load && cnt_r == ccs_pkg::RD_GAP) |=> tx_r == 8'h00)
    else $error("unreadable address returned data");

  cov_tw_write: cover property (@(posedge clk) tw_we);
  cov_tw_read:  cover property (@(posedge clk) req_s && !req_q);
  cov_i2c_wr:   cover property (@(posedge clk) i2c_we);
  cov_i2c_rd2:  cover property (@(posedge clk)
    st_r == ccs_pkg::ST_RACK && scl_fall && mack_r);

endmodule // ccs_ctrl_port
`default_nettype wire

//--- src/ccs_pkg.sv
// Constants, types and helpers for the codec control serial port.
// Assumes a single 200 MHz core clock and a host that masters the link.
// Overview of operation
// - 3-wire frame: direction, 7-bit address, 8-bit data
// - 3-wire bits sampled on serial clock rise
// - 3-wire write lands at chip select rise
// - 3-wire read drives D7..D0 from eighth fall
// - 3-wire data line released unless sending data
// - Power-down pin low resets every register
// - 3-wire readable: 00-11, 24-2B, 30-31 hex
// - Bus address 001001 plus address-select pin
// - Matching address acknowledged; direction 1 reads
// - Acknowledge every byte received in writes
// - Write counter increments, wraps after 4F
// - Read counter increments, wraps after 4F
// - Bus readable: 00-0C, 0E-11, 24-2B, 30-31 hex
// - Current read sends counter byte, then increments
// - Master no-acknowledge then stop ends sending
// - Bus data changes only while clock low

package ccs_pkg;

  // Register file shape and reset contents
  localparam int         REG_COUNT = 80;
  localparam logic [6:0] REG_LAST  = 7'h4F;
  localparam logic [7:0] REG_INIT  = 8'h00;

  // Readable address windows
  localparam logic [6:0] RD_HI0  = 7'h11;
  localparam logic [6:0] RD_GAP  = 7'h0D;
  localparam logic [6:0] RD_LO1  = 7'h24;
  localparam logic [6:0] RD_HI1  = 7'h2B;
  localparam logic [6:0] RD_LO2  = 7'h30;
  localparam logic [6:0] RD_HI2  = 7'h31;

  // Two-wire bus address, upper six bits (001001)
  localparam logic [5:0] DEV_ADDR_HI = 6'h09;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [2:0] BIT_TOP     = 3'h7;

  // 3-wire framing
  localparam logic       TW_DIR_READ   = 1'b1;
  localparam logic [4:0] TW_HDR_BITS   = 5'h08;
  localparam logic [4:0] TW_FRAME_BITS = 5'h10;
  localparam logic [4:0] TW_LAST_BIT   = 5'h0F;
  localparam logic [4:0] TW_HDR_LAST   = 5'h07;

  // Synchroniser reset pattern: cs, pdn, cad, mode, scl, sda, req
  localparam logic [6:0] SYNC_INIT = 7'h66;

  // One 3-wire frame as it sits in the shift register
  typedef struct packed {
    logic       dir;
    logic [6:0] addr;
    logic [7:0] data;
  } ccs_tw_frame_s;

  // Two-wire slave states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_A, ST_REG, ST_ACK_R,
    ST_WDATA, ST_ACK_W, ST_RDATA, ST_RACK
  } ccs_i2c_st_e;

  // Address gives real data; the bus interface also hides 0D
  function automatic logic reg_readable(input logic [6:0] a,
                                        input logic       i2c);
    reg_readable = (a <= RD_HI0 && !(i2c && a == RD_GAP)) ||
                   (a >= RD_LO1 && a <= RD_HI1) ||
                   (a >= RD_LO2 && a <= RD_HI2);
  endfunction

endpackage

//--- src/ccs_sync.sv
// Two-stage synchroniser for a group of independent levels.
// Assumes each bit is a quasi-static level; no word coherence.
`timescale 1ns/1ps
`default_nettype none
module ccs_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= INIT;
      q      <= INIT;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // ccs_sync
`default_nettype wire

//--- dv/ccs_host_model.sv
// Host model: masters the 3-wire link and the two-wire bus.
// Assumes the bench resolves both shared data lines and calls the tasks.
`timescale 1ns/1ps
`default_nettype none
module ccs_host_model (
  // Core clock paces the two-wire bus
  input  wire logic clk,
  // 3-wire link
  output logic      control_serial_clock,
  output logic      serial_select_low,
  output logic      host_data,
  input  wire logic data_level,
  input  wire logic dev_oe,
  // Two-wire link, open drain with pull-up
  output logic      scl,
  output logic      sda_host,
  input  wire logic sda_level
);
  localparam int  Q    = 125;   // Quarter bit, 400 kHz bus
  localparam real HALF = 62.5;  // Half of a 125 ns serial clock
  logic [7:0] unstable;         // Device data moved while clock high

  // Idle levels; serial clock stands still outside frames
  initial begin
    control_serial_clock = 1'b0;
    serial_select_low    = 1'b1;
    host_data            = 1'b0;
    scl                  = 1'b1;
    sda_host             = 1'b1;
    unstable             = 8'h00;
  end

  // Frame of nbits bits, MSB first; select stays low for the caller
  task automatic tw_frame(input ccs_pkg::ccs_tw_frame_s f, input int nbits,
                          output logic [7:0] rd, output logic oe_bad);
    logic [15:0] v;
    v      = f;
    rd     = 8'h00;
    oe_bad = 1'b0;
    #3.7;
    serial_select_low = 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      // Released in read data: toggle so a stale copy never passes
      host_data = (f.dir && i < 8) ? ~host_data : v[i];
      #HALF;
      control_serial_clock = 1'b1;
      if (f.dir && i < 8) rd[i] = data_level;
      if (dev_oe !== (f.dir && i < 8)) oe_bad = 1'b1;
      #HALF;
      control_serial_clock = 1'b0;
    end
    #HALF;
  endtask

  // Select high ends the frame; gap is long enough for the core
  task automatic tw_end;
    serial_select_low = 1'b1;
    host_data = ~host_data;
    #(2 * HALF);
  endtask

  task automatic qw;
    repeat (Q) @(negedge clk);
  endtask

  // Start, also used as repeated start
  task automatic i2c_start;
    sda_host = 1'b1;
    qw;
    scl = 1'b1;
    qw;
    sda_host = 1'b0;
    qw;
    scl = 1'b0;
    qw;
  endtask

  task automatic i2c_stop;
    sda_host = 1'b0;
    qw;
    scl = 1'b1;
    qw;
    sda_host = 1'b1;
    qw;
  endtask

  // One bit; data only moves while clock is low
  task automatic i2c_bit(input logic b, output logic s);
    sda_host = b;
    qw;
    scl = 1'b1;
    qw;
    s = sda_level;
    qw;
    if (sda_level !== s) unstable = unstable + 8'h01;
    scl = 1'b0;
    qw;
  endtask

  // Byte out, MSB first, then sample the acknowledge
  task automatic i2c_wr(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) i2c_bit(b[i], s);
    i2c_bit(1'b1, s);
    ack = ~s;
  endtask

  // Byte in; acknowledge asks for the next one
  task automatic i2c_rd(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) i2c_bit(1'b1, b[i]);
    i2c_bit(~more, s);
  endtask
endmodule // ccs_host_model
`default_nettype wire

//--- dv/ccs_ctrl_port_tb.sv
// Testbench for the control port: 3-wire and two-wire register access.
// Assumes the host model drives both links and the design has no params.
`timescale 1ns/1ps
`default_nettype none
module ccs_ctrl_port_tb;
  logic clk, rst_n, chip_reset_low, bus_address_select_pin, i2c_mode_sel;
  logic control_serial_clock, serial_select_low, host_data, dat_level;
  logic control_data_line_out, control_data_line_oe;
  logic scl, sda_host, sda_level, i2c_data_out, i2c_data_oe;
  logic [8*ccs_pkg::REG_COUNT-1:0] config_image;
  int   miscompares, checked;

  // Wire levels: data line shared, two-wire bus pulled up
  assign dat_level = control_data_line_oe ? control_data_line_out : host_data;
  assign sda_level = sda_host & ~(i2c_data_oe & ~i2c_data_out);

  ccs_ctrl_port dut (
    .clk(clk), .rst_n(rst_n), .chip_reset_low(chip_reset_low),
    .bus_address_select_pin(bus_address_select_pin),
    .i2c_mode_sel(i2c_mode_sel),
    .control_serial_clock(control_serial_clock),
    .serial_select_low(serial_select_low),
    .control_data_line_in(dat_level),
    .control_data_line_out(control_data_line_out),
    .control_data_line_oe(control_data_line_oe),
    .i2c_clock_in(scl), .i2c_data_in(sda_level),
    .i2c_data_out(i2c_data_out), .i2c_data_oe(i2c_data_oe),
    .config_image(config_image)
  );

  ccs_host_model host (
    .clk(clk), .control_serial_clock(control_serial_clock),
    .serial_select_low(serial_select_low), .host_data(host_data),
    .data_level(dat_level), .dev_oe(control_data_line_oe),
    .scl(scl), .sda_host(sda_host), .sda_level(sda_level)
  );

  task automatic chk_byte(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  function automatic logic [7:0] img(input logic [6:0] a);
    return config_image[8*int'(a) +: 8];
  endfunction

  task automatic end_of_test;
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic tw_wr(input logic [6:0] a, input logic [7:0] d,
                       input int nbits);
    logic [7:0] rd;
    logic       bad;
    host.tw_frame(ccs_pkg::ccs_tw_frame_s'({1'b0, a, d}), nbits, rd, bad);
    host.tw_end;
    repeat (10) @(negedge clk);
    chk_bit("drive during write", 1'b0, bad);
  endtask

  task automatic tw_rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] rd;
    logic       bad;
    host.tw_frame(ccs_pkg::ccs_tw_frame_s'({1'b1, a, 8'h00}), 16, rd, bad);
    chk_bit("read drive window", 1'b0, bad);
    chk_byte("3-wire read", exp, rd);
    host.tw_end;
    @(negedge clk);
    chk_bit("line released", 1'b0, control_data_line_oe);
  endtask

  // Write stays pending until select rises
  task automatic t_tw_write;
    logic [7:0] rd;
    logic       bad;
    host.tw_frame(ccs_pkg::ccs_tw_frame_s'({1'b0, 7'h0A, 8'h5A}), 16, rd,
                  bad);
    repeat (20) @(negedge clk);
    chk_byte("before select rise", 8'h00, img(7'h0A));
    host.tw_end;
    repeat (10) @(negedge clk);
    chk_byte("3-wire write", 8'h5A, img(7'h0A));
    tw_wr(7'h0B, 8'hFF, 15);
    chk_byte("short frame", 8'h00, img(7'h0B));
  endtask

  // Power-down pin clears what was written
  task automatic t_power_down;
    chip_reset_low = 1'b0;
    repeat (10) @(negedge clk);
    chip_reset_low = 1'b1;
    repeat (10) @(negedge clk);
    chk_byte("power-down clear", 8'h00, img(7'h0A));
  endtask

  task automatic t_i2c_write;
    logic       ack;
    logic [7:0] d [3] = '{8'hA5, 8'h5A, 8'hC3};
    i2c_mode_sel = 1'b1;
    repeat (10) @(negedge clk);
    host.i2c_start;
    host.i2c_wr(8'h26, ack);
    chk_bit("address ack", 1'b1, ack);
    host.i2c_wr(8'h4F, ack);
    chk_bit("register ack", 1'b1, ack);
    for (int k = 0; k < 3; k++) begin
      host.i2c_wr(d[k], ack);
      chk_bit("data ack", 1'b1, ack);
    end
    host.i2c_stop;
    chk_byte("burst at 4F", 8'hA5, img(7'h4F));
    chk_byte("burst wrap 00", 8'h5A, img(7'h00));
    chk_byte("burst wrap 01", 8'hC3, img(7'h01));
  endtask

  task automatic rand_rd(input logic [6:0] a, output logic [7:0] b);
    logic ack;
    host.i2c_start;
    host.i2c_wr(8'h26, ack);
    host.i2c_wr({1'b0, a}, ack);
    host.i2c_start;
    host.i2c_wr(8'h27, ack);
    chk_bit("read address ack", 1'b1, ack);
    host.i2c_rd(1'b0, b);
    host.i2c_stop;
    chk_bit("released after stop", 1'b0, i2c_data_oe);
  endtask

  task automatic t_i2c_read;
    logic       ack;
    logic [7:0] b;
    rand_rd(7'h4F, b);
    chk_byte("random read hole", 8'h00, b);
    host.i2c_start;
    host.i2c_wr(8'h27, ack);
    host.i2c_rd(1'b1, b);
    chk_byte("current read wrap", 8'h5A, b);
    host.i2c_rd(1'b0, b);
    chk_byte("continued read", 8'hC3, b);
    host.i2c_stop;
    rand_rd(7'h0D, b);
    chk_byte("hidden address", 8'h00, b);
    host.i2c_start;
    host.i2c_wr(8'h24, ack);
    chk_bit("foreign address", 1'b0, ack);
    host.i2c_stop;
    chk_byte("bus data stable", 8'h00, host.unstable);
  endtask

  // 200 MHz core clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Main sequence, inputs changed at falling edges
  initial begin
    rst_n = 1'b0;
    chip_reset_low = 1'b1;
    bus_address_select_pin = 1'b1;
    i2c_mode_sel = 1'b0;
    miscompares = 0;
    checked = 0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    for (int a = 0; a < ccs_pkg::REG_COUNT; a++) begin
      chk_byte("reset value", 8'h00, img(7'(a)));
    end
    chk_bit("idle line", 1'b0, control_data_line_oe);
    t_tw_write;
    t_power_down;
    tw_wr(7'h12, 8'h81, 16);
    chk_byte("unreadable written", 8'h81, img(7'h12));
    tw_wr(7'h0D, 8'h3C, 16);
    tw_rd(7'h0D, 8'h3C);
    chk_byte("read wrote nothing", 8'h00, img(7'h3C));
    tw_rd(7'h12, 8'h00);
    t_i2c_write;
    t_i2c_read;
    end_of_test;
  end

  // Watchdog sized above the roughly 85k cycles the tests need
  initial begin
    repeat (100000) @(posedge clk);
    chk_bit("watchdog", 1'b0, 1'b1);
    end_of_test;
  end
endmodule // ccs_ctrl_port_tb
`default_nettype wire
